// ===== hw/iisr_regs.vh
// register offsets, command bits and timing counts for the identity and scratch bank
`ifndef IISR_REGS_VH
`define IISR_REGS_VH
`define IISR_OFF_FACTORY_YEAR 7'h70
`define IISR_OFF_PRODUCT_IDENT 7'h72
`define IISR_OFF_LOT_CODE 7'h74
`define IISR_OFF_SCRATCH_A 7'h76
`define IISR_OFF_SCRATCH_B 7'h78
`define IISR_OFF_SCRATCH_C 7'h7A
`define IISR_OFF_FLASH_LO 7'h7C
`define IISR_OFF_FLASH_HI 7'h7E
`define IISR_OFF_GLOBAL_CMD 7'h68
`define IISR_CMD_FLASH_UPDATE 3
`define IISR_SCRATCH_RESET 16'h0000
`define IISR_FLASH_TIME_US 100
`define IISR_CLK_MHZ 50
`define IISR_FLASH_CYCLES (`IISR_FLASH_TIME_US * `IISR_CLK_MHZ)
`endif

// ===== hw/iisr_flash_ctl.v
// flash update sequencer: busy window, write counter and status
`timescale 1ns/1ps
`default_nettype none
`include "iisr_regs.vh"
module iisr_flash_ctl #(
  parameter CYCLES = `IISR_FLASH_CYCLES
)
(
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // command and result
  input wire start_i,
  input wire fail_i,
  output reg busy_o,
  output reg done_o,
  output reg fail_o,
  output reg [31:0] count_o
);
  reg [31:0] timer;
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
      count_o <= 32'h00000000;
      timer <= 32'h00000000;
    end
    else
    begin
      done_o <= 1'b0;
      if (!busy_o && start_i)
      begin
        busy_o <= 1'b1;
        timer <= CYCLES - 1;
      end
      else if (busy_o)
      begin
        if (timer == 32'h00000000)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          fail_o <= fail_i;
          if (!fail_i)
            count_o <= count_o + 32'h00000001;
        end
        else
          timer <= timer - 32'h00000001;
      end
    end
  end
endmodule
`default_nettype wire

// ===== hw/iisr_bank.v
// identity, scratch and flash write count registers of the upper register map
//
// Notes on behaviour
// - read-only BCD factory year word
// - read-only fixed product identity word
// - read-only lot serial number word
// - three read/write scratch words hold writes
// - scratch persists only after flash update command
// - 32-bit flash count split low/high words
// - flash update copies config, reports status bit
// - commands busy: halt data, ignore requests
`timescale 1ns/1ps
`default_nettype none
`include "iisr_regs.vh"
module iisr_bank #(
  parameter [15:0] FACTORY_YEAR = 16'h2017,
  // arbitrary neutral value
  parameter [15:0] PRODUCT_IDENT = 16'h1234,
  parameter [15:0] LOT_CODE = 16'h0001,
  parameter FLASH_CYCLES = `IISR_FLASH_CYCLES
)
(
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // register access, 16-bit words at even byte addresses
  input wire [6:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  output reg [15:0] reg_rdata_o,
  output reg reg_rvalid_o,
  // flash interface
  input wire flash_fail_i,
  output reg [47:0] flash_image_o,
  output reg flash_update_fail_o,
  // command activity
  output reg cmd_busy_o,
  output reg data_halt_o
);
  // command sequencer states, binary coded
  localparam [1:0] CMD_IDLE = 2'b00;
  localparam [1:0] CMD_LAUNCH = 2'b01;
  localparam [1:0] CMD_RUN = 2'b10;

  reg [15:0] scratch_a;
  reg [15:0] scratch_b;
  reg [15:0] scratch_c;
  reg [1:0] cmd_state;
  reg [1:0] next_cmd_state;
  wire flash_start;
  wire busy;
  wire done;
  wire fail;
  wire [31:0] count;
  wire [15:0] writes_lo;
  wire [15:0] writes_hi;
  wire [6:0] hit_addr;
  wire cmd_active;
  wire flash_cmd;
  wire accept_rd;
  wire accept_wr;

  // word address: the odd byte of a pair selects the same word
  function [6:0] word_of;
    input [6:0] a;
    begin
      word_of = {a[6:1], 1'b0};
    end
  endfunction

  function [15:0] read_mux;
    input [6:0] a;
    input [15:0] sa;
    input [15:0] sb;
    input [15:0] sc;
    input [15:0] lo;
    input [15:0] hi;
    begin
      case (word_of(a))
        `IISR_OFF_FACTORY_YEAR: read_mux = FACTORY_YEAR;
        `IISR_OFF_PRODUCT_IDENT: read_mux = PRODUCT_IDENT;
        `IISR_OFF_LOT_CODE: read_mux = LOT_CODE;
        `IISR_OFF_SCRATCH_A: read_mux = sa;
        `IISR_OFF_SCRATCH_B: read_mux = sb;
        `IISR_OFF_SCRATCH_C: read_mux = sc;
        `IISR_OFF_FLASH_LO: read_mux = lo;
        `IISR_OFF_FLASH_HI: read_mux = hi;
        default: read_mux = 16'h0000;
      endcase
    end
  endfunction

  assign flash_start = (cmd_state == CMD_LAUNCH);
  assign cmd_active = busy | flash_start;
  // requests during a command are dropped, not queued, since the host must poll
  assign accept_rd = reg_rd_i && !cmd_active;
  assign accept_wr = reg_wr_i && !cmd_active;
  assign hit_addr = word_of(reg_addr_i);
  // only the flash update bit is acted on; other command bits live elsewhere
  assign flash_cmd = accept_wr && (hit_addr == `IISR_OFF_GLOBAL_CMD) && reg_wdata_i[`IISR_CMD_FLASH_UPDATE];
  // no latch between halves: a host reading both may see a carry in between
  assign writes_lo = count[15:0];
  assign writes_hi = count[31:16];

  // the sequencer times the window and counts writes that complete without failure
  iisr_flash_ctl #(
    .CYCLES(FLASH_CYCLES)
  )
  u_flash
  (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(flash_start),
    .fail_i(flash_fail_i),
    .busy_o(busy),
    .done_o(done),
    .fail_o(fail),
    .count_o(count)
  );

  // launch lasts one cycle, then the sequencer owns the busy window
  always @*
  begin
    next_cmd_state = cmd_state;
    case (cmd_state)
      CMD_IDLE:
      begin
        if (flash_cmd)
          next_cmd_state = CMD_LAUNCH;
      end
      CMD_LAUNCH:
        next_cmd_state = CMD_RUN;
      CMD_RUN:
      begin
        // a new command may land in the cycle the window closes
        if (flash_cmd)
          next_cmd_state = CMD_LAUNCH;
        else if (!busy)
          next_cmd_state = CMD_IDLE;
      end
      default:
        next_cmd_state = CMD_IDLE;
    endcase
  end

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      cmd_state <= CMD_IDLE;
    else
      cmd_state <= next_cmd_state;
  end

  // scratch words are volatile; only the image below survives power loss
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      scratch_a <= `IISR_SCRATCH_RESET;
      scratch_b <= `IISR_SCRATCH_RESET;
      scratch_c <= `IISR_SCRATCH_RESET;
    end
    else if (accept_wr)
    begin
      case (hit_addr)
        `IISR_OFF_SCRATCH_A: scratch_a <= reg_wdata_i;
        `IISR_OFF_SCRATCH_B: scratch_b <= reg_wdata_i;
        `IISR_OFF_SCRATCH_C: scratch_c <= reg_wdata_i;
        // read-only and unmapped words ignore writes
        default: ;
      endcase
    end
  end

  // rdata holds until the next accepted read
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      reg_rdata_o <= 16'h0000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= accept_rd;
      if (accept_rd)
        reg_rdata_o <= read_mux(reg_addr_i, scratch_a, scratch_b, scratch_c, writes_lo, writes_hi);
    end
  end

  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
    begin
      flash_image_o <= 48'h000000000000;
      flash_update_fail_o <= 1'b0;
      cmd_busy_o <= 1'b0;
    end
    else
    begin
      // snapshot at launch; writes stay refused until the window closes
      if (flash_start)
        flash_image_o <= {scratch_c, scratch_b, scratch_a};
      if (done)
        flash_update_fail_o <= fail;
      cmd_busy_o <= cmd_active;
    end
  end

  // data production halts for the same window as cmd_busy_o, one cycle after the register interface starts refusing
  always @(posedge ref_clk_i)
  begin
    if (sys_rst_i)
      data_halt_o <= 1'b0;
    else
      data_halt_o <= cmd_active;
  end
endmodule
`default_nettype wire

// ===== verification/iisr_bank_sva.sv
// checker on the bank's register and busy ports
`timescale 1ns/1ps
`default_nettype none
module iisr_bank_sva #(parameter [15:0] Y = 16'h0, P = 16'h0, L = 16'h0)
(
  // watched ports
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire [6:0] reg_addr_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [15:0] reg_wdata_i,
  input wire [15:0] reg_rdata_o,
  input wire reg_rvalid_o,
  input wire cmd_busy_o,
  input wire data_halt_o
);
  logic [5:0] pa;
  always @(posedge ref_clk_i) pa <= reg_addr_i[6:1];
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_rvalid_cause: assert property (reg_rvalid_o |-> $past(reg_rd_i)) else $error("rvalid");
  a_busy_refuse: assert property (reg_rd_i && cmd_busy_o |=> !reg_rvalid_o) else $error("refuse");
  a_halt_busy: assert property (data_halt_o == cmd_busy_o) else $error("halt");
  a_year_word: assert property (reg_rvalid_o && pa == 6'h38 |-> reg_rdata_o == Y) else $error("year");
  a_ident_word: assert property (reg_rvalid_o && pa == 6'h39 |-> reg_rdata_o == P) else $error("ident");
  a_lot_word: assert property (reg_rvalid_o && pa == 6'h3A |-> reg_rdata_o == L) else $error("lot");
  a_cmd_start: assert property (reg_wr_i && !cmd_busy_o && reg_addr_i[6:1] == 6'h34
    && reg_wdata_i[3] |-> ##2 cmd_busy_o) else $error("start");
  a_busy_span: assert property ($rose(cmd_busy_o) |-> cmd_busy_o[*3] ##[1:6] !cmd_busy_o) else $error("span");
endmodule
bind iisr_bank iisr_bank_sva #(.Y(FACTORY_YEAR), .P(PRODUCT_IDENT), .L(LOT_CODE)) i_sva (.*);
`default_nettype wire

// ===== verification/iisr_host.sv
// host model issuing one-cycle register strobes
`timescale 1ns/1ps
`default_nettype none
module iisr_host
(
  // register bus toward the bank
  input wire ref_clk_i,
  output logic [6:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] wdata_o
);
  logic [15:0] exp_q[$];
  initial {addr_o, wr_o, rd_o, wdata_o} = '0;
  // op 0 write, 1 answered read, 2 read that must be dropped
  task xfer(input [1:0] op, input [6:0] a, input [15:0] d);
  begin
    @(posedge ref_clk_i) #1;
    {addr_o, wdata_o, wr_o, rd_o} = {a, d, op == 2'h0, op != 2'h0};
    if (op == 2'h1) exp_q.push_back(d);
    @(posedge ref_clk_i) #1;
    // released address and data lines invert and the strobes clear, so a stale value never matches by luck
    {addr_o, wdata_o, wr_o, rd_o} = {~a, ~d, 2'h0};
  end
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// bench for the identity and scratch bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin error_cnt++; $display("CHECK FAILED %s %h %h", n, e, g); end end
module tb;
  logic ref_clk_i = 0, sys_rst_i = 1, flash_fail_i = 0;
  wire reg_wr_i, reg_rd_i, reg_rvalid_o, flash_update_fail_o, cmd_busy_o, data_halt_o;
  wire [6:0] reg_addr_i;
  wire [15:0] reg_wdata_i, reg_rdata_o;
  wire [47:0] flash_image_o;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  logic [15:0] s = 16'hA715, v;
  logic [47:0] img;
  logic [6:0] a;
  iisr_bank #(.FLASH_CYCLES(4)) i_iisr_bank (.*);
  iisr_host host (.ref_clk_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
  always #10 ref_clk_i = ~ref_clk_i;
  function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task print_verdict;
  begin
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  // busy only rises two edges after the command write
  task idle;
  begin
    repeat (3) @(posedge ref_clk_i);
    while (cmd_busy_o !== 1'b0) @(posedge ref_clk_i);
    repeat (2) @(posedge ref_clk_i);
  end
  endtask
  always @(posedge ref_clk_i)
  begin
    if (reg_rvalid_o === 1'b1)
    begin
      v = host.exp_q.pop_front();
      `CHK("rdata", v, reg_rdata_o)
    end
    if (++cyc == 2000)
    begin
      error_cnt++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (5) @(posedge ref_clk_i);
    #1 sys_rst_i = 0;
    host.xfer(2'h1, 7'h70, 16'h2017);
    host.xfer(2'h0, 7'h73, 16'hFFFF);
    repeat (3) host.xfer(2'h1, 7'h73, 16'h1234);
    host.xfer(2'h1, 7'h75, 16'h0001);
    host.xfer(2'h1, 7'h60, 16'h0000);
    for (a = 7'h76; a < 7'h7C; a += 7'h02)
    begin
      s = lfsr(s);
      img = {s, img[47:16]};
      host.xfer(2'h0, a, s);
    end
    for (a = 7'h76; a < 7'h7C; a += 7'h02)
      host.xfer(2'h1, a, img[(a - 7'h76) * 8 +: 16]);
    host.xfer(2'h0, 7'h68, 16'h0008);
    repeat (2) host.xfer(2'h2, 7'h7C, 16'h0000);
    idle;
    `CHK("image", img, flash_image_o)
    `CHK("status", 1'b0, flash_update_fail_o)
    host.xfer(2'h1, 7'h7C, 16'h0001);
    host.xfer(2'h1, 7'h7E, 16'h0000);
    #1 flash_fail_i = 1;
    host.xfer(2'h0, 7'h68, 16'h0008);
    idle;
    `CHK("status", 1'b1, flash_update_fail_o)
    host.xfer(2'h1, 7'h7D, 16'h0001);
    repeat (2) @(posedge ref_clk_i);
    `CHK("pending", 0, host.exp_q.size())
    print_verdict;
  end
endmodule
`default_nettype wire
